// >>> hw/otfs_params.svh
`ifndef OTFS_PARAMS_SVH
`define OTFS_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OTFS_SEL0_OFF     8'h00
`define OTFS_SEL1_OFF     8'h04
`define OTFS_SEL2_OFF     8'h08
`define OTFS_REMOTE_OFF   8'h0C
`define OTFS_CTRL_OFF     8'h10
`define OTFS_THRESH_OFF   8'h14
`define OTFS_COUNT_OFF    8'h18
`define OTFS_STATE_OFF    8'h1C
`define OTFS_ISTAT_OFF    8'h20
`define OTFS_IMASK_OFF    8'h24

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define OTFS_SEL0_RST     8'hFF
`define OTFS_SEL1_RST     8'hFF
`define OTFS_SEL2_RST     8'h63
`define OTFS_REMOTE_RST   3'h0
`define OTFS_CTRL_RST     1'h0
`define OTFS_THRESH_RST   16'hFFFF
`define OTFS_IMASK_RST    6'h00

// ----------------------------------------------------------------
// selection codes
// ----------------------------------------------------------------
`define OTFS_CODE_SU      8'h01
`define OTFS_CODE_RETRY   8'h40
`define OTFS_CODE_EXT     8'h44
`define OTFS_CODE_LIFE    8'h5A
`define OTFS_CODE_HWF     8'h5B
`define OTFS_CODE_PULSE   8'h5D
`define OTFS_CODE_MAINT   8'h5F
`define OTFS_CODE_REM     8'h60
`define OTFS_CODE_COMM    8'h62
`define OTFS_CODE_TRIP    8'h63
`define OTFS_CODE_NEG     8'h64
`define OTFS_CODE_MAX     8'hC7
`define OTFS_CODE_NOFUNC  8'hFF

// ----------------------------------------------------------------
// function vector bit positions
// ----------------------------------------------------------------
`define OTFS_FN_SU        0
`define OTFS_FN_RETRY     1
`define OTFS_FN_EXT       2
`define OTFS_FN_LIFE      3
`define OTFS_FN_HWF       4
`define OTFS_FN_PULSE     5
`define OTFS_FN_MAINT     6
`define OTFS_FN_REM       7
`define OTFS_FN_COMM      8
`define OTFS_FN_TRIP      9

// ----------------------------------------------------------------
// pin vector bit positions
// ----------------------------------------------------------------
`define OTFS_PIN_RETRY    0
`define OTFS_PIN_MAINOFF  1
`define OTFS_PIN_EXT24    2
`define OTFS_PIN_LIFE     3
`define OTFS_PIN_HWF      4
`define OTFS_PIN_PULSE    5
`define OTFS_PIN_COMM     6
`define OTFS_PIN_TRIP     7
`define OTFS_PIN_FRESET   8
`define OTFS_PIN_SU       9
`define OTFS_PIN_RUN      10

// ----------------------------------------------------------------
// interrupt status bit positions and sizes
// ----------------------------------------------------------------
`define OTFS_IRQ_TRIP     0
`define OTFS_IRQ_LIFE     1
`define OTFS_IRQ_HWF      2
`define OTFS_IRQ_MAINT    3
`define OTFS_IRQ_COMM     4
`define OTFS_IRQ_REFUSED  5

`define OTFS_NUM_TERM     3
`define OTFS_TERM_RELAY   2
`define OTFS_RESP_OKAY    2'h0
`define OTFS_RESP_SLVERR  2'h2

`endif

// >>> hw/otfs_pkg.sv
package otfs_pkg;
    typedef logic [7:0] sel_code_t;
    typedef logic [9:0] func_vec_t;
    typedef logic [10:0] pin_vec_t;
    typedef logic [5:0] irq_vec_t;
endpackage

// >>> hw/terminal_func_mux.sv
`timescale 1ns/1ps
`include "otfs_params.svh"
module terminal_func_mux (
    input wire otfs_pkg::sel_code_t code,
    input wire otfs_pkg::func_vec_t func,
    input wire logic remote_bit,
    output logic conduct
);
    import otfs_pkg::*;

    // ----------------------------------------------------------------
    // polarity split
    // ----------------------------------------------------------------
    wire logic in_range = (code <= `OTFS_CODE_MAX);
    wire logic neg = in_range && (code >= `OTFS_CODE_NEG);
    wire sel_code_t base = neg ? 8'(code - `OTFS_CODE_NEG) : code;

    logic active;
    logic known;

    // ----------------------------------------------------------------
    // function select
    // ----------------------------------------------------------------
    always_comb begin
        active = 1'b0;
        known = 1'b1;
        case (base)
            `OTFS_CODE_SU: active = func[`OTFS_FN_SU];
            `OTFS_CODE_RETRY: active = func[`OTFS_FN_RETRY];
            `OTFS_CODE_EXT: active = func[`OTFS_FN_EXT];
            `OTFS_CODE_LIFE: active = func[`OTFS_FN_LIFE];
            `OTFS_CODE_HWF: active = func[`OTFS_FN_HWF];
            `OTFS_CODE_PULSE: active = func[`OTFS_FN_PULSE];
            `OTFS_CODE_MAINT: active = func[`OTFS_FN_MAINT];
            `OTFS_CODE_REM: active = remote_bit;
            `OTFS_CODE_COMM: active = func[`OTFS_FN_COMM];
            `OTFS_CODE_TRIP: active = func[`OTFS_FN_TRIP];
            default: known = 1'b0;
        endcase
    end

    // unmodelled or no-function codes stay off in both polarities
    assign conduct = in_range && known && (active ^ neg);
endmodule

// >>> hw/output_terminal_function_select.sv
// What this block does
// - code 64 or 164 shows that automatic retry after a fault is running.
// - code 68 or 168 shows main power off while logic runs on an external 24V supply.
// - code 90 or 190 carries the life alarm for worn parts such as the control capacitor.
// - code 91 or 191 carries the fault caused by internal circuit failure or miswiring.
// - code 93 or 193 carries the pulse train of average current and maintenance timer.
// - the pulse-train code is refused on the relay contact terminal.
// - code 95 or 195 is active once the maintenance count reaches its threshold.
// - code 96 or 196 follows the host-written remote output bit of that terminal.
// - code 98 or 198 carries the communication warning while it is present.
// - code 99 or 199 shows the trip raised when a protective function stops output.
// - the trip indication stays until the fault is reset and falls only then.
// - several terminals may hold one code and then follow the same status, except code 96 or 196, which follows each terminal's own remote bit.
// - codes 0 to 99 conduct when active, codes 100 to 199 do not conduct when active.
// - up-to-speed may chatter while ramping but is steady with zero ramp time.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "otfs_params.svh"
module output_terminal_function_select (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire otfs_pkg::pin_vec_t status_pins,
    input wire logic [15:0] maint_timer_count,
    output logic [2:0] terminal_out,
    output logic irq
);
    import otfs_pkg::*;
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    pin_vec_t sync1_r;
    pin_vec_t sync2_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else if (ce) begin
            sync1_r <= status_pins;
            sync2_r <= sync1_r;
        end
    end
    // ----------------------------------------------------------------
    // axi write channel capture
    // ----------------------------------------------------------------
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] wr_addr_r;
    logic [31:0] wr_data_r;
    logic [3:0] wr_strb_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    wire logic aw_take = awvalid && awready_r;
    wire logic w_take = wvalid && wready_r;
    wire logic wr_fire = aw_held_r && w_held_r && !bvalid_r;
    wire logic lane0 = wr_strb_r[0];
    wire logic lane1 = wr_strb_r[1];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else if (ce) begin
            if (aw_take) begin
                aw_held_r <= 1'b1;
                wr_addr_r <= awaddr;
            end else if (wr_fire) begin
                aw_held_r <= 1'b0;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wr_data_r <= 32'h0000_0000;
            wr_strb_r <= 4'h0;
        end else if (ce) begin
            if (w_take) begin
                w_held_r <= 1'b1;
                wr_data_r <= wdata;
                wr_strb_r <= wstrb;
            end else if (wr_fire) begin
                w_held_r <= 1'b0;
            end
        end
    end
    // ready stays low from the take until the response is accepted, so one write at a time
    wire logic awready_nxt = !(aw_held_r || aw_take || (bvalid_r && !bready));
    wire logic wready_nxt = !(w_held_r || w_take || (bvalid_r && !bready));
    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    wire logic hit_remote = (wr_addr_r == `OTFS_REMOTE_OFF);
    wire logic hit_ctrl = (wr_addr_r == `OTFS_CTRL_OFF);
    wire logic hit_thresh = (wr_addr_r == `OTFS_THRESH_OFF);
    wire logic hit_count = (wr_addr_r == `OTFS_COUNT_OFF);
    wire logic hit_state = (wr_addr_r == `OTFS_STATE_OFF);
    wire logic hit_istat = (wr_addr_r == `OTFS_ISTAT_OFF);
    wire logic hit_imask = (wr_addr_r == `OTFS_IMASK_OFF);
    logic [2:0] sel_hit;
    logic [2:0] sel_bad;
    wire logic wr_mapped = (|sel_hit) || hit_remote || hit_ctrl || hit_thresh
        || hit_count || hit_state || hit_istat || hit_imask;
    // read-only registers and refused codes answer with an error
    wire logic wr_err = !wr_mapped || (|sel_bad) || hit_count || hit_state;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `OTFS_RESP_OKAY;
        end else if (ce) begin
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_err ? `OTFS_RESP_SLVERR : `OTFS_RESP_OKAY;
            end else if (bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    logic [2:0] remote_r;
    logic ctrl_zero_ramp_r;
    logic [15:0] thresh_r;
    irq_vec_t imask_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            remote_r <= `OTFS_REMOTE_RST;
            ctrl_zero_ramp_r <= `OTFS_CTRL_RST;
            imask_r <= `OTFS_IMASK_RST;
        end else if (ce && wr_fire && lane0) begin
            if (hit_remote) remote_r <= wr_data_r[2:0];
            if (hit_ctrl) ctrl_zero_ramp_r <= wr_data_r[0];
            if (hit_imask) imask_r <= wr_data_r[5:0];
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            thresh_r <= `OTFS_THRESH_RST;
        end else if (ce && wr_fire && hit_thresh) begin
            if (lane0) thresh_r[7:0] <= wr_data_r[7:0];
            if (lane1) thresh_r[15:8] <= wr_data_r[15:8];
        end
    end
    // ----------------------------------------------------------------
    // status conditioning
    // ----------------------------------------------------------------
    logic trip_r;
    logic su_hold_r;
    logic maint_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trip_r <= 1'b0;
            su_hold_r <= 1'b0;
            maint_r <= 1'b0;
        end else if (ce) begin
            // a new trip in the reset cycle keeps the indication up
            if (sync2_r[`OTFS_PIN_TRIP]) trip_r <= 1'b1;
            else if (sync2_r[`OTFS_PIN_FRESET]) trip_r <= 1'b0;
            if (!sync2_r[`OTFS_PIN_RUN]) su_hold_r <= 1'b0;
            else if (sync2_r[`OTFS_PIN_SU]) su_hold_r <= 1'b1;
            maint_r <= (maint_timer_count >= thresh_r);
        end
    end
    // with zero ramp time the indication is held from reach until stop
    wire logic su_ind = ctrl_zero_ramp_r ? su_hold_r : sync2_r[`OTFS_PIN_SU];
    wire logic ext_op = sync2_r[`OTFS_PIN_MAINOFF] && sync2_r[`OTFS_PIN_EXT24];
    wire func_vec_t func = {
        trip_r,
        sync2_r[`OTFS_PIN_COMM],
        1'b0,
        maint_r,
        sync2_r[`OTFS_PIN_PULSE],
        sync2_r[`OTFS_PIN_HWF],
        sync2_r[`OTFS_PIN_LIFE],
        ext_op,
        sync2_r[`OTFS_PIN_RETRY],
        su_ind
    };
    // ----------------------------------------------------------------
    // per-terminal selection and drive
    // ----------------------------------------------------------------
    sel_code_t sel_r [0:2];
    logic [2:0] term_nxt;
    logic [2:0] term_r;
    genvar gi;
    generate
        for (gi = 0; gi < `OTFS_NUM_TERM; gi++) begin : g_term
            localparam logic [7:0] SEL_OFF = 8'(`OTFS_SEL0_OFF + (gi * 4));
            localparam sel_code_t SEL_RST = (gi == 0) ? `OTFS_SEL0_RST :
                (gi == 1) ? `OTFS_SEL1_RST : `OTFS_SEL2_RST;
            wire sel_code_t new_code = wr_data_r[7:0];
            wire logic code_ok = (new_code <= `OTFS_CODE_MAX)
                || (new_code == `OTFS_CODE_NOFUNC);
            wire logic is_pulse = (new_code == `OTFS_CODE_PULSE)
                || (new_code == 8'(`OTFS_CODE_PULSE + `OTFS_CODE_NEG));
            wire logic relay_ok = !((gi == `OTFS_TERM_RELAY) && is_pulse);

            assign sel_hit[gi] = (wr_addr_r == SEL_OFF);
            assign sel_bad[gi] = sel_hit[gi] && lane0 && !(code_ok && relay_ok);

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    sel_r[gi] <= SEL_RST;
                end else if (ce && wr_fire && sel_hit[gi] && lane0 && !sel_bad[gi]) begin
                    sel_r[gi] <= new_code;
                end
            end

            // every terminal reads the one shared vector, so codes may repeat
            terminal_func_mux u_mux (
                .code(sel_r[gi]),
                .func(func),
                .remote_bit(remote_r[gi]),
                .conduct(term_nxt[gi])
            );
        end
    endgenerate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            term_r <= 3'h0;
        end else if (ce) begin
            term_r <= term_nxt;
        end
    end

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    irq_vec_t istat_r;
    irq_vec_t ev_prev_r;
    logic irq_r;
    logic refused_r;
    wire irq_vec_t ev_now = {refused_r, func[`OTFS_FN_COMM], maint_r,
        func[`OTFS_FN_HWF], func[`OTFS_FN_LIFE], trip_r};
    wire irq_vec_t ev_set = ev_now & ~ev_prev_r;
    wire irq_vec_t ev_clr = (wr_fire && hit_istat && lane0) ? wr_data_r[5:0] : 6'h00;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            istat_r <= 6'h00;
            ev_prev_r <= 6'h00;
            refused_r <= 1'b0;
            irq_r <= 1'b0;
        end else if (ce) begin
            // set after clear, so an event in the clear cycle survives
            istat_r <= (istat_r & ~ev_clr) | ev_set;
            ev_prev_r <= ev_now;
            refused_r <= wr_fire && (|sel_bad) && !refused_r;
            irq_r <= |(istat_r & imask_r);
        end
    end

    // ----------------------------------------------------------------
    // axi read channel
    // ----------------------------------------------------------------
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    wire logic ar_take = arvalid && arready_r;
    wire logic rd_sel0 = (araddr == `OTFS_SEL0_OFF);
    wire logic rd_sel1 = (araddr == `OTFS_SEL1_OFF);
    wire logic rd_sel2 = (araddr == `OTFS_SEL2_OFF);
    wire logic rd_remote = (araddr == `OTFS_REMOTE_OFF);
    wire logic rd_ctrl = (araddr == `OTFS_CTRL_OFF);
    wire logic rd_thresh = (araddr == `OTFS_THRESH_OFF);
    wire logic rd_count = (araddr == `OTFS_COUNT_OFF);
    wire logic rd_state = (araddr == `OTFS_STATE_OFF);
    wire logic rd_istat = (araddr == `OTFS_ISTAT_OFF);
    wire logic rd_imask = (araddr == `OTFS_IMASK_OFF);
    wire logic rd_mapped = rd_sel0 || rd_sel1 || rd_sel2 || rd_remote || rd_ctrl
        || rd_thresh || rd_count || rd_state || rd_istat || rd_imask;
    wire logic [31:0] rd_word =
        rd_sel0 ? {24'h00_0000, sel_r[0]} :
        rd_sel1 ? {24'h00_0000, sel_r[1]} :
        rd_sel2 ? {24'h00_0000, sel_r[2]} :
        rd_remote ? {29'h0000_0000, remote_r} :
        rd_ctrl ? {31'h0000_0000, ctrl_zero_ramp_r} :
        rd_thresh ? {16'h0000, thresh_r} :
        rd_count ? {16'h0000, maint_timer_count} :
        rd_state ? {13'h0000, term_r, 6'h00, func} :
        rd_istat ? {26'h000_0000, istat_r} :
        rd_imask ? {26'h000_0000, imask_r} : 32'h0000_0000;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `OTFS_RESP_OKAY;
        end else if (ce) begin
            arready_r <= !rvalid_r && !ar_take;
            if (ar_take) begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_word;
                rresp_r <= rd_mapped ? `OTFS_RESP_OKAY : `OTFS_RESP_SLVERR;
            end else if (rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign terminal_out = term_r;
    assign irq = irq_r;
endmodule

// >>> tb/otfs_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------
// register bus and output checks
// ----------------------------------------
module otfs_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic [2:0] terminal_out,
    input wire logic irq
);
    default clocking dcb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    bresp_drop_a: assert property (bvalid && bready && ce |=> !bvalid)
        else $error("write response repeated");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rresp}))
        else $error("read response dropped early");
    wr_block_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    rd_block_a: assert property (rvalid |-> !arready)
        else $error("read taken while data pending");
    // fixed two-edge write answer keeps the bus simple to budget
    wr_latency_a: assert property ((awvalid && awready && wvalid && wready && ce) ##1 ce
        |-> !bvalid ##1 bvalid)
        else $error("write answer late");
    rd_latency_a: assert property (arvalid && arready && ce |=> rvalid)
        else $error("read answer late");
    err_data_a: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0000_0000)
        else $error("refused read returns data");
    reset_state_a: assert property ($rose(aresetn) |-> !bvalid && !rvalid && !irq
        && terminal_out == 3'h0)
        else $error("outputs not idle after reset");
endmodule

bind output_terminal_function_select otfs_checker i_chk (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .terminal_out(terminal_out), .irq(irq));

// >>> tb/term_equipment.sv
`timescale 1ns/1ps
// ----------------------------------------
// equipment wired to the terminals
// ----------------------------------------
module term_equipment (
    input wire logic aclk,
    input wire otfs_pkg::pin_vec_t pins_req,
    input wire logic [2:0] terminal_out,
    output otfs_pkg::pin_vec_t status_pins,
    output logic [2:0] seen
);
    import otfs_pkg::*;
    initial status_pins = '0;
    // levels move just after the edge, as the drive logic would change them
    always @(posedge aclk) begin
        status_pins <= pins_req;
        seen <= terminal_out;
    end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`include "otfs_params.svh"
// ----------------------------------------
// terminal selection bench
// ----------------------------------------
module tb_top;
    import otfs_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic [1:0] bresp, rresp;
    logic [2:0] terminal_out, seen;
    pin_vec_t pins = '0;
    pin_vec_t status_pins;
    logic [15:0] count = 16'h0000;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    initial begin
        forever #12.5 aclk = ~aclk;
    end

    output_terminal_function_select i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .status_pins(status_pins), .maint_timer_count(count),
        .terminal_out(terminal_out), .irq(irq));

    term_equipment i_eq (.aclk(aclk), .pins_req(pins), .terminal_out(terminal_out),
        .status_pins(status_pins), .seen(seen));

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // equipment flop, two sync flops, condition and output stages, seen flop, with margin
    task automatic term(input logic [2:0] e);
        repeat (8) @(posedge aclk);
        chk({29'h0, seen}, {29'h0, e});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
    endtask

    task automatic set3(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] c2);
        wr(`OTFS_SEL0_OFF, {24'h0, c0}, 2'h0);
        wr(`OTFS_SEL1_OFF, {24'h0, c1}, 2'h0);
        wr(`OTFS_SEL2_OFF, {24'h0, c2}, 2'h0);
    endtask

    task automatic t_reset();
        logic [7:0] a [7] = '{`OTFS_SEL0_OFF, `OTFS_SEL1_OFF, `OTFS_SEL2_OFF,
            `OTFS_REMOTE_OFF, `OTFS_CTRL_OFF, `OTFS_THRESH_OFF, `OTFS_IMASK_OFF};
        logic [31:0] e [7] = '{32'h0000_00FF, 32'h0000_00FF, 32'h0000_0063, 32'h0000_0000,
            32'h0000_0000, 32'h0000_FFFF, 32'h0000_0000};
        for (int i = 0; i < 7; i++) rd(a[i], e[i], 2'h0);
        chk({28'h0, irq, seen}, 32'h0000_0000);
        $display("test reset finished");
    endtask

    task automatic t_codes();
        logic [7:0] c [5] = '{8'd64, 8'd68, 8'd90, 8'd91, 8'd98};
        pin_vec_t p [5] = '{11'h001, 11'h006, 11'h008, 11'h010, 11'h040};
        for (int i = 0; i < 5; i++) begin
            set3(c[i], c[i] + 8'd100, c[i]);
            pins <= p[i];
            term(3'b101);
            pins <= '0;
            term(3'b010);
        end
        $display("test codes finished");
    endtask

    task automatic t_trip();
        set3(8'd99, 8'd199, 8'd0);
        pins <= 11'h080;
        term(3'b001);
        pins <= 11'h000;
        term(3'b001);
        pins <= 11'h100;
        term(3'b010);
        pins <= '0;
        $display("test trip finished");
    endtask

    task automatic t_maint();
        set3(8'd95, 8'd195, 8'd0);
        wr(`OTFS_THRESH_OFF, 32'h0000_0010, 2'h0);
        count <= 16'h000F;
        term(3'b010);
        rd(`OTFS_COUNT_OFF, 32'h0000_000F, 2'h0);
        count <= 16'h0010;
        term(3'b001);
        ce <= 1'b0;
        count <= 16'h0000;
        term(3'b001);
        ce <= 1'b1;
        count <= 16'hFFFF;
        term(3'b001);
        $display("test maint finished");
    endtask

    task automatic t_remote();
        set3(8'd96, 8'd196, 8'd96);
        wr(`OTFS_REMOTE_OFF, 32'h0000_0005, 2'h0);
        term(3'b111);
        wr(`OTFS_REMOTE_OFF, 32'h0000_0002, 2'h0);
        term(3'b000);
        $display("test remote finished");
    endtask

    task automatic t_refuse();
        set3(8'd93, 8'd193, 8'd99);
        wr(`OTFS_SEL2_OFF, 32'h0000_005D, 2'h2);
        rd(`OTFS_SEL2_OFF, 32'h0000_0063, 2'h0);
        pins <= 11'h020;
        term(3'b001);
        pins <= '0;
        wr(`OTFS_IMASK_OFF, 32'h0000_0020, 2'h0);
        term(3'b010);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(`OTFS_ISTAT_OFF, 32'h0000_0020, 2'h0);
        term(3'b010);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(`OTFS_COUNT_OFF, 32'h0000_0000, 2'h2);
        rd(8'h80, 32'h0000_0000, 2'h2);
        $display("test refuse finished");
    endtask

    task automatic t_speed();
        set3(8'd1, 8'd101, 8'd0);
        wr(`OTFS_CTRL_OFF, 32'h0000_0001, 2'h0);
        pins <= 11'h600;
        term(3'b001);
        pins <= 11'h400;
        term(3'b001);
        pins <= 11'h000;
        term(3'b010);
        wr(`OTFS_CTRL_OFF, 32'h0000_0000, 2'h0);
        pins <= 11'h600;
        term(3'b001);
        pins <= 11'h400;
        term(3'b010);
        $display("test speed finished");
    endtask

    task automatic t_nofunc();
        set3(8'hFF, 8'hFF, 8'hFF);
        pins <= 11'h7FF;
        term(3'b000);
        $display("test nofunc finished");
    endtask

    // ceiling well above the few hundred cycles the sequence needs
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_codes();
        t_trip();
        t_maint();
        t_remote();
        t_refuse();
        t_speed();
        t_nofunc();
        final_report();
    end
endmodule
